// >>> verilog/cpc_map.vh
// Register map, field positions and reset values of the CSI-2 receive packet checker
// Overview of operation
// - Packets with data types 0x13 to 0x17 are accepted and processed like any other legal packet.
// - Data types 0x13 to 0x17 never set an unknown-type flag nor raise the error interrupt.
// - The unknown-type flags sit in bits 12 to 15 of the second error status register.
// - Bits 12 to 15 of the second error mask keep those flags off the interrupt, whatever type set them.
// - The payload valid strobe is high for the payload bytes of long packets carrying real data.
// - The payload valid strobe stays low for the payload of null and blanking long packets.
// - With four lanes the payload counter stops at the end of a long packet, not counting idle time.
// - Correct data gives no CRC error however long the blanking is and without line start or end packets.
`ifndef CPC_MAP_VH
`define CPC_MAP_VH

// Register byte offsets
`define CPC_OFS_CTRL         8'h00
`define CPC_OFS_STATUS1      8'h04
`define CPC_OFS_MASK1        8'h08
`define CPC_OFS_STATUS2      8'h0c
`define CPC_OFS_SECOND_ERROR_MASK        8'h10
`define CPC_OFS_PAY_COUNT    8'h14
`define CPC_OFS_LAST_HDR     8'h18
`define CPC_OFS_PKT_COUNT    8'h1c

// Control fields
`define CPC_CTRL_ENABLE      0
`define CPC_CTRL_LANES_LO    1
`define CPC_CTRL_LANES_HI    2
`define CPC_CTRL_CRC_EN      3
`define CPC_CTRL_RESET       4'hf

// First status / mask fields
`define CPC_ST1_CRC_ERR      0
`define CPC_ST1_TRUNC        1
`define CPC_ST1_FRAME_START  2
`define CPC_ST1_FRAME_END    3
`define CPC_ST1_LINE_START   4
`define CPC_ST1_LINE_END     5
`define CPC_ST1_WIDTH        6
`define CPC_MASK1_RESET      6'h3f

// Second status / mask: unknown type flag per virtual channel
`define CPC_ST2_UNK_LO       12
`define CPC_ST2_UNK_HI       15
`define CPC_SECOND_ERROR_MASK_RESET      4'hf

// Data type codes
`define CPC_DT_FRAME_START   6'h00
`define CPC_DT_FRAME_END     6'h01
`define CPC_DT_LINE_START    6'h02
`define CPC_DT_LINE_END      6'h03
`define CPC_DT_LONG_FIRST    6'h10
`define CPC_DT_NULL          6'h10
`define CPC_DT_BLANKING      6'h11
`define CPC_DT_RSVD_FIRST    6'h13
`define CPC_DT_RSVD_LAST     6'h17
`define CPC_DT_UNKNOWN_FIRST 6'h38

// CRC
`define CPC_CRC_INIT         16'hffff
`define CPC_CRC_POLY         16'h8408

`endif

// >>> verilog/cpc_crc16.v
// One-byte step of the reflected 16-bit payload checksum
`timescale 1ns/100ps
module cpc_crc16
(
	// Running value and new byte
	input  wire [15:0] crc_in,
	input  wire [7:0]  data_in,
	// Updated value
	output reg  [15:0] crc_out
);
`include "cpc_map.vh"

	integer i;

	always @*
	begin
		crc_out = crc_in;
		for (i = 0; i < 8; i = i + 1)
		begin
			if (crc_out[0] ^ data_in[i])
				crc_out = (crc_out >> 1) ^ `CPC_CRC_POLY;
			else
				crc_out = crc_out >> 1;
		end
	end

endmodule

// >>> verilog/cpc_packet_checker.v
// CSI-2 receive packet checker: lane sampling, packet parsing, checksum, APB registers
`timescale 1ns/100ps
module cpc_packet_checker
#(
	parameter LANE_BYTES = 4
)
(
	// System
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Receiver lanes
	input  wire        receiver_lane_clock,
	input  wire        rx_burst_valid,
	input  wire [31:0] rx_lane_data,
	// Payload toward image processing
	output reg  [7:0]  pix_data,
	output reg         pix_valid,
	output reg  [5:0]  pix_data_type,
	output reg  [1:0]  pix_channel,
	// Interrupt
	output wire        irq
);
`include "cpc_map.vh"

	localparam ST_HDR  = 2'd0;
	localparam ST_PAY  = 2'd1;
	localparam ST_CRC  = 2'd2;
	localparam ST_SKIP = 2'd3;

	// Registers
	reg  [3:0]  ctrl;
	reg  [`CPC_ST1_WIDTH-1:0] status1;
	reg  [`CPC_ST1_WIDTH-1:0] mask1;
	reg  [3:0]  second_error_status;
	reg  [3:0]  second_error_mask;
	reg  [15:0] last_pay_count;
	reg  [15:0] pkt_count;

	// Lane synchronisers
	reg         lclk_s1;
	reg         lclk_s2;
	reg         lclk_s3;
	reg         lvld_s1;
	reg         lvld_s2;
	reg         lvld_d;
	reg  [31:0] ldat_s1;
	reg  [31:0] ldat_s2;

	// Byte shifter
	reg  [31:0] word;
	reg  [2:0]  bytes_left;
	reg         end_pend;

	// Parser
	reg  [1:0]  state;
	reg  [1:0]  idx;
	reg  [7:0]  di;
	reg  [15:0] wc;
	reg  [7:0]  crc_lo;
	reg  [15:0] crc;
	reg  [15:0] pay_count;
	reg         real_data;

	wire        link_edge;
	wire        burst_fall;
	wire [2:0]  lane_count;
	wire        byte_stb;
	wire [7:0]  byte_val;
	wire [15:0] crc_next;
	wire        burst_end;
	wire [5:0]  hdr_dt;
	wire        unknown_dt;
	wire        acc_wr;
	wire        setup_rd;
	wire        addr_ok;

	reg  [`CPC_ST1_WIDTH-1:0] set1;
	reg  [3:0]  set2;

	cpc_crc16 u_crc
	(
		.crc_in  (crc),
		.data_in (byte_val),
		.crc_out (crc_next)
	);

	// Lane pins are foreign to pclk; everything passes two flops before use
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lclk_s1 <= 1'b0;
			lclk_s2 <= 1'b0;
			lclk_s3 <= 1'b0;
			lvld_s1 <= 1'b0;
			lvld_s2 <= 1'b0;
			lvld_d  <= 1'b0;
			ldat_s1 <= 32'h0000_0000;
			ldat_s2 <= 32'h0000_0000;
		end
		else
		begin
			lclk_s1 <= receiver_lane_clock;
			lclk_s2 <= lclk_s1;
			lclk_s3 <= lclk_s2;
			lvld_s1 <= rx_burst_valid;
			lvld_s2 <= lvld_s1;
			lvld_d  <= lvld_s2;
			ldat_s1 <= rx_lane_data;
			ldat_s2 <= ldat_s1;
		end
	end

	assign link_edge  = lclk_s2 & ~lclk_s3;
	assign burst_fall = lvld_d & ~lvld_s2;

	// Lane count: 0 one lane, 1 two lanes, else four lanes
	assign lane_count = (ctrl[`CPC_CTRL_LANES_HI:`CPC_CTRL_LANES_LO] == 2'd0) ? 3'd1 :
	                    (ctrl[`CPC_CTRL_LANES_HI:`CPC_CTRL_LANES_LO] == 2'd1) ? 3'd2 :
	                    LANE_BYTES[2:0];

	// Each link word is drained one byte per pclk; eight pclk per link cycle leave slack
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word       <= 32'h0000_0000;
			bytes_left <= 3'd0;
			end_pend   <= 1'b0;
		end
		else
		begin
			if (link_edge && lvld_s2 && ctrl[`CPC_CTRL_ENABLE])
			begin
				word       <= ldat_s2;
				bytes_left <= lane_count;
			end
			else if (bytes_left != 3'd0)
			begin
				word       <= {8'h00, word[31:8]};
				bytes_left <= bytes_left - 3'd1;
			end
			if (burst_fall)
				end_pend <= 1'b1;
			else if (bytes_left == 3'd0)
				end_pend <= 1'b0;
		end
	end

	assign byte_stb  = (bytes_left != 3'd0);
	assign byte_val  = word[7:0];
	// The burst end waits until the last word is drained so no byte is lost
	assign burst_end = (end_pend | burst_fall) & (bytes_left == 3'd0);

	assign hdr_dt     = di[5:0];
	// Reserved types below the unknown range count as legal
	assign unknown_dt = (hdr_dt >= `CPC_DT_UNKNOWN_FIRST);

	// Packet parser
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state          <= ST_HDR;
			idx            <= 2'd0;
			di             <= 8'h00;
			wc             <= 16'h0000;
			crc_lo         <= 8'h00;
			crc            <= `CPC_CRC_INIT;
			pay_count      <= 16'h0000;
			real_data      <= 1'b0;
			last_pay_count <= 16'h0000;
			pkt_count      <= 16'h0000;
			pix_data       <= 8'h00;
			pix_valid      <= 1'b0;
			pix_data_type  <= 6'h00;
			pix_channel    <= 2'd0;
			set1           <= {`CPC_ST1_WIDTH{1'b0}};
			set2           <= 4'h0;
		end
		else
		begin
			pix_valid <= 1'b0;
			set1      <= {`CPC_ST1_WIDTH{1'b0}};
			set2      <= 4'h0;
			if (burst_end)
			begin
				// A burst that stops inside a long packet is reported as truncated
				if (state == ST_PAY || state == ST_CRC)
					set1[`CPC_ST1_TRUNC] <= 1'b1;
				state <= ST_HDR;
				idx   <= 2'd0;
			end
			else if (byte_stb)
			begin
				case (state)
				ST_HDR:
				begin
					idx <= idx + 2'd1;
					case (idx)
					2'd0: di <= byte_val;
					2'd1: wc[7:0] <= byte_val;
					2'd2: wc[15:8] <= byte_val;
					default:
					begin
						pkt_count <= pkt_count + 16'h0001;
						if (unknown_dt)
							set2[di[7:6]] <= 1'b1;
						if (hdr_dt < `CPC_DT_LONG_FIRST)
						begin
							state <= ST_SKIP;
							set1[`CPC_ST1_FRAME_START] <= (hdr_dt == `CPC_DT_FRAME_START);
							set1[`CPC_ST1_FRAME_END]   <= (hdr_dt == `CPC_DT_FRAME_END);
							set1[`CPC_ST1_LINE_START]  <= (hdr_dt == `CPC_DT_LINE_START);
							set1[`CPC_ST1_LINE_END]    <= (hdr_dt == `CPC_DT_LINE_END);
						end
						else
						begin
							// Every long type except null and blanking, reserved ones included, is delivered
							crc       <= `CPC_CRC_INIT;
							pay_count <= 16'h0000;
							real_data <= (hdr_dt != `CPC_DT_NULL) &&
							             (hdr_dt != `CPC_DT_BLANKING);
							state     <= (wc == 16'h0000) ? ST_CRC : ST_PAY;
							idx       <= 2'd0;
						end
					end
					endcase
				end
				ST_PAY:
				begin
					crc           <= crc_next;
					pay_count     <= pay_count + 16'h0001;
					pix_data      <= byte_val;
					pix_valid     <= real_data;
					pix_data_type <= hdr_dt;
					pix_channel   <= di[7:6];
					// Counting stops at the last payload byte, never across idle lanes
					if (pay_count == wc - 16'h0001)
					begin
						state <= ST_CRC;
						idx   <= 2'd0;
					end
				end
				ST_CRC:
				begin
					idx <= idx + 2'd1;
					if (idx == 2'd0)
						crc_lo <= byte_val;
					else
					begin
						last_pay_count <= pay_count;
						// Empty payloads compare against the untouched seed
						if (ctrl[`CPC_CTRL_CRC_EN] && ({byte_val, crc_lo} != crc))
							set1[`CPC_ST1_CRC_ERR] <= 1'b1;
						state <= ST_SKIP;
					end
				end
				// Lane padding after a packet end is ignored until the burst closes
				default:
				begin
					state <= ST_SKIP;
				end
				endcase
			end
		end
	end

	// APB: no wait states; read data is captured in the setup cycle
	assign pready   = 1'b1;
	assign acc_wr   = psel & penable & pwrite;
	assign setup_rd = psel & ~penable & ~pwrite;
	assign addr_ok  = (paddr == `CPC_OFS_CTRL)      || (paddr == `CPC_OFS_STATUS1)  ||
	                  (paddr == `CPC_OFS_MASK1)     || (paddr == `CPC_OFS_STATUS2)  ||
	                  (paddr == `CPC_OFS_SECOND_ERROR_MASK)     || (paddr == `CPC_OFS_PAY_COUNT) ||
	                  (paddr == `CPC_OFS_LAST_HDR)  || (paddr == `CPC_OFS_PKT_COUNT);
	assign pslverr  = psel & penable & ~addr_ok;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl                <= `CPC_CTRL_RESET;
			mask1               <= `CPC_MASK1_RESET;
			second_error_mask   <= `CPC_SECOND_ERROR_MASK_RESET;
			status1             <= {`CPC_ST1_WIDTH{1'b0}};
			second_error_status <= 4'h0;
		end
		else
		begin
			if (acc_wr && paddr == `CPC_OFS_CTRL)
				ctrl <= pwdata[3:0];
			if (acc_wr && paddr == `CPC_OFS_MASK1)
				mask1 <= pwdata[`CPC_ST1_WIDTH-1:0];
			if (acc_wr && paddr == `CPC_OFS_SECOND_ERROR_MASK)
				second_error_mask <= pwdata[`CPC_ST2_UNK_HI:`CPC_ST2_UNK_LO];
			// Write one to clear; a new event in the same cycle wins over the clear
			if (acc_wr && paddr == `CPC_OFS_STATUS1)
				status1 <= (status1 & ~pwdata[`CPC_ST1_WIDTH-1:0]) | set1;
			else
				status1 <= status1 | set1;
			if (acc_wr && paddr == `CPC_OFS_STATUS2)
				second_error_status <= (second_error_status &
				                       ~pwdata[`CPC_ST2_UNK_HI:`CPC_ST2_UNK_LO]) | set2;
			else
				second_error_status <= second_error_status | set2;
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup_rd)
		begin
			case (paddr)
			`CPC_OFS_CTRL:      prdata <= {28'h0000000, ctrl};
			`CPC_OFS_STATUS1:   prdata <= {26'h0, status1};
			`CPC_OFS_MASK1:     prdata <= {26'h0, mask1};
			`CPC_OFS_STATUS2:   prdata <= {16'h0000, second_error_status, 12'h000};
			`CPC_OFS_SECOND_ERROR_MASK:     prdata <= {16'h0000, second_error_mask, 12'h000};
			`CPC_OFS_PAY_COUNT: prdata <= {16'h0000, last_pay_count};
			`CPC_OFS_LAST_HDR:  prdata <= {8'h00, wc, di};
			`CPC_OFS_PKT_COUNT: prdata <= {16'h0000, pkt_count};
			default:            prdata <= 32'h0000_0000;
			endcase
		end
	end

	// The unknown-type mask gates regardless of which type set the flag
	assign irq = (|(status1 & ~mask1)) |
	             (|(second_error_status & ~second_error_mask));

endmodule

// >>> bench/cpc_props.sv
// Port assertions for the packet checker
`timescale 1ns/100ps
module cpc_props
(
	// System
	input wire logic	pclk,
	input wire logic	presetn,
	// APB
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	// Payload and interrupt
	input wire logic	pix_valid,
	input wire logic [5:0]	pix_data_type,
	input wire logic	irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shadow of both masks, so irq can be judged from the bus alone
	logic [5:0]	m1;
	logic [3:0]	m2;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			m1 <= 6'h3f;
			m2 <= 4'hf;
		end
		else if (psel && penable && pwrite && paddr == 8'h08)
			m1 <= pwdata[5:0];
		else if (psel && penable && pwrite && paddr == 8'h10)
			m2 <= pwdata[15:12];
	pay_type_a: assert property (pix_valid |-> pix_data_type >= 6'h12)
		else $error("strobe on filler");
	rdy_a: assert property (pready)
		else $error("pready low");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("stray pslverr");
	unmap_a: assert property (psel && penable && paddr > 8'h1c |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access");
	map_ok_a: assert property (psel && penable && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	rd_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("prdata moved");
	reset_quiet_a: assert property ($rose(presetn) |-> !irq && !pix_valid)
		else $error("busy after reset");
	all_masked_a: assert property (&m1 && &m2 |-> !irq)
		else $error("masked irq");
	cover property (pix_valid);
	cover property (irq);
	cover property (pslverr);
endmodule
bind cpc_packet_checker cpc_props i_cpc_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pix_valid(pix_valid),
	.pix_data_type(pix_data_type), .irq(irq));

// >>> bench/cpc_cam.sv
// Camera transmitter model on one, two or four lanes
`timescale 1ns/100ps
module cpc_cam
(
	// Lanes
	output logic	receiver_lane_clock,
	output logic	rx_burst_valid,
	output logic [31:0]	rx_lane_data
);
	// Bytes per link cycle; the bench sets it to match the lane count it programs
	int	nb = 4;
	initial
	begin
		receiver_lane_clock = 1'b0;
		rx_burst_valid = 1'b0;
		rx_lane_data = 32'h0;
	end
	// One packet a burst; lane clock stands still between bursts
	task send(input logic [5:0] dt, input logic [1:0] vc, input logic [15:0] wc, input logic bad);
		logic [7:0]	q[$];
		logic [7:0]	b;
		logic [15:0]	c;
		logic [31:0]	w;
		int	i;
		int	j;
		q = '{{vc, dt}, wc[7:0], wc[15:8], 8'h00};
		c = 16'hffff;
		if (dt >= 6'h10)
		begin
			for (i = 0; i < wc; i++)
			begin
				b = 8'(i * 3 + 1);
				q.push_back(b);
				c = c ^ {8'h00, b};
				for (j = 0; j < 8; j++)
					c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
			end
			if (bad)
				c = ~c;
			q.push_back(c[7:0]);
			q.push_back(c[15:8]);
		end
		while (q.size() % 4)
			q.push_back(8'h00);
		w = 32'h0;
		rx_burst_valid <= 1'b1;
		for (i = 0; i < q.size(); i += nb)
		begin
			w = 32'h0;
			for (j = 0; j < nb; j++)
				w[8*j +: 8] = q[i+j];
			rx_lane_data <= w;
			#80 receiver_lane_clock <= 1'b1;
			#80 receiver_lane_clock <= 1'b0;
		end
		// Released lines show garbage, not the last word
		rx_lane_data <= ~w;
		#160 rx_burst_valid <= 1'b0;
	endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench for the packet checker
`timescale 1ns/100ps
`include "cpc_map.vh"
module tb;
	localparam logic [7:0] S1 = `CPC_OFS_STATUS1, S2 = `CPC_OFS_STATUS2;
	localparam logic [7:0] M1 = `CPC_OFS_MASK1, M2 = `CPC_OFS_SECOND_ERROR_MASK;
	logic	pclk, presetn, psel, penable, pwrite;
	logic [7:0]	paddr, lastb;
	logic [5:0]	lastt;
	logic [1:0]	lastc;
	wire [5:0]	pix_dt;
	wire [1:0]	pix_ch;
	logic [31:0]	pwdata;
	wire [31:0]	prdata, ld;
	wire [7:0]	pix_data;
	wire	pready, pslverr, lclk, bv, irq, pix_valid;
	int	n_fail = 0, num_checks = 0, npix = 0, n;
	cpc_packet_checker i_cpc_packet_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .receiver_lane_clock(lclk), .rx_burst_valid(bv),
		.rx_lane_data(ld), .pix_data(pix_data), .pix_valid(pix_valid), .pix_data_type(pix_dt),
		.pix_channel(pix_ch), .irq(irq));
	cpc_cam i_cpc_cam (.receiver_lane_clock(lclk), .rx_burst_valid(bv), .rx_lane_data(ld));
	always #10 pclk = ~pclk;
	always @(posedge pclk)
		if (pix_valid)
		begin
			npix <= npix + 1;
			lastb <= pix_data;
			lastt <= pix_dt;
			lastc <= pix_ch;
		end
	task results;
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("Error %s exp %h got %h", s, e, g);
			n_fail++;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50)
		begin
			n_fail++;
			results;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task rdc(input string s, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(s, e, r);
	endtask
	task ichk(input logic e);
		@(negedge pclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	task pkt(input logic [5:0] t, input logic [1:0] v, input logic [15:0] w, input logic b);
		n = npix;
		// Start on a rising edge so every lane change is a non-blocking update there
		@(posedge pclk);
		i_cpc_cam.send(t, v, w, b);
		repeat (16) @(posedge pclk);
	endtask
	initial
	begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc("ctrl", `CPC_OFS_CTRL, 32'hf);
		rdc("mask1", M1, 32'h3f);
		rdc("second_error_mask", M2, 32'hf000);
		rdc("unmapped", 8'h40, 32'h0);
		wr(M1, 32'h0);
		wr(M2, 32'h0);
		for (int t = 8'h13; t <= 8'h17; t++)
		begin
			pkt(6'(t), 2'h0, 16'h4, 1'b0);
			chk("rsvd pix", 4, 32'(npix - n));
			rdc("rsvd count", `CPC_OFS_PAY_COUNT, 32'h4);
			rdc("rsvd flags", S2, 32'h0);
			ichk(1'b0);
		end
		rdc("crc ok", S1, 32'h0);
		for (int t = 8'h10; t <= 8'h11; t++)
		begin
			pkt(6'(t), 2'h0, 16'h8, 1'b0);
			chk("filler pix", 0, 32'(npix - n));
		end
		pkt(6'h2a, 2'h1, 16'h8, 1'b0);
		chk("data pix", 8, 32'(npix - n));
		chk("last byte", 32'h16, {24'h0, lastb});
		chk("data type", 32'h2a, {26'h0, lastt});
		chk("data vc", 32'h1, {30'h0, lastc});
		pkt(6'h38, 2'h2, 16'h0, 1'b0);
		rdc("unknown flag", S2, 32'h4000);
		ichk(1'b1);
		wr(M2, 32'h4000);
		ichk(1'b0);
		wr(M2, 32'h0);
		wr(S2, 32'h4000);
		rdc("flag clear", S2, 32'h0);
		pkt(6'h2a, 2'h0, 16'h6, 1'b1);
		rdc("crc bad", S1, 32'h1);
		ichk(1'b1);
		wr(S1, 32'h1);
		ichk(1'b0);
		pkt(6'h00, 2'h0, 16'h0, 1'b0);
		pkt(6'h2b, 2'h0, 16'hc, 1'b0);
		repeat (2000) @(posedge pclk);
		rdc("pay count", `CPC_OFS_PAY_COUNT, 32'hc);
		pkt(6'h01, 2'h0, 16'h0, 1'b0);
		rdc("crc idle", S1, 32'hc);
		wr(S1, 32'hc);
		pkt(6'h02, 2'h0, 16'h0, 1'b0);
		pkt(6'h2b, 2'h0, 16'h4, 1'b0);
		pkt(6'h03, 2'h0, 16'h0, 1'b0);
		rdc("line flags", S1, 32'h30);
		rdc("line count", `CPC_OFS_PAY_COUNT, 32'h4);
		wr(S1, 32'h30);
		wr(`CPC_OFS_CTRL, 32'h7);
		pkt(6'h2a, 2'h0, 16'h6, 1'b1);
		rdc("crc off", S1, 32'h0);
		wr(`CPC_OFS_CTRL, 32'he);
		pkt(6'h2a, 2'h0, 16'h6, 1'b0);
		chk("off pix", 0, 32'(npix - n));
		wr(`CPC_OFS_CTRL, 32'h9);
		i_cpc_cam.nb = 1;
		pkt(6'h2a, 2'h3, 16'h5, 1'b0);
		chk("1 lane pix", 5, 32'(npix - n));
		chk("1 lane byte", 32'hd, {24'h0, lastb});
		rdc("1 lane count", `CPC_OFS_PAY_COUNT, 32'h5);
		wr(`CPC_OFS_CTRL, 32'hb);
		i_cpc_cam.nb = 2;
		pkt(6'h2a, 2'h2, 16'h6, 1'b0);
		chk("2 lane pix", 6, 32'(npix - n));
		chk("2 lane vc", 32'h2, {30'h0, lastc});
		rdc("lane crc", S1, 32'h0);
		rdc("last hdr", `CPC_OFS_LAST_HDR, 32'h0000_06aa);
		rdc("pkt count", `CPC_OFS_PKT_COUNT, 32'h13);
		results;
	end
	initial
	begin
		repeat (100000) @(posedge pclk);
		n_fail++;
		results;
	end
endmodule
